//--- core/dmct_defines.svh
`ifndef DMCT_DEFINES_SVH
`define DMCT_DEFINES_SVH

// byte port register offsets (3-bit address)
`define DMCT_ADDR_CTRL      3'h0
`define DMCT_ADDR_STAT      3'h1
`define DMCT_ADDR_CNT_HI    3'h2
`define DMCT_ADDR_CNT_LO    3'h3
`define DMCT_ADDR_CMP_HI    3'h4
`define DMCT_ADDR_CMP_LO    3'h5
`define DMCT_ADDR_CLKSTOP   3'h6

// reset values
`define DMCT_RST_COUNT      8'h00
`define DMCT_RST_COMPARE    8'hFF
`define DMCT_RST_CTRL       8'h00
`define DMCT_RST_STAT       8'h00
`define DMCT_RST_CLKSTOP    8'hFF
`define DMCT_BYTE_MAX       8'hFF
`define DMCT_BYTE_ZERO      8'h00

// control register fields
`define DMCT_CTRL_HOL       7
`define DMCT_CTRL_HSEL_MSB  6
`define DMCT_CTRL_HSEL_LSB  4
`define DMCT_CTRL_LOL       3
`define DMCT_CTRL_LSEL_MSB  2
`define DMCT_CTRL_LSEL_LSB  0

// control/status register fields
`define DMCT_STAT_OVF_H     7
`define DMCT_STAT_CMF_H     6
`define DMCT_STAT_OVIE_H    5
`define DMCT_STAT_CCLR_H    4
`define DMCT_STAT_OVF_L     3
`define DMCT_STAT_CMF_L     2
`define DMCT_STAT_OVIE_L    1
`define DMCT_STAT_CCLR_L    0
`define DMCT_STAT_FLAGS     8'hCC

// clock stop register: timer standby bit
`define DMCT_CLKSTOP_TIMER  2

// clock-select low bits and prescaler taps
`define DMCT_SEL_SUB        2'h3
`define DMCT_SEL_SUB_FULL   3'h7
`define DMCT_PRE_DIV32      5'h1F
`define DMCT_PRE_DIV16      4'hF
`define DMCT_PRE_DIV4       2'h3
`define DMCT_SUB_DIV4       2'h3

`endif

//--- core/dmct_pkg.sv
package dmct_pkg;
  // one data byte of the peripheral port
  typedef logic [7:0] dmct_byte_t;
  // three-bit clock selection field
  typedef logic [2:0] dmct_sel_t;
endpackage : dmct_pkg

//--- core/dmct_sync_edge.sv
module dmct_sync_edge (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // asynchronous input
  input  wire logic asyncIn,
  // synchronised rising and falling edge pulses
  output logic      rise,
  output logic      fall
);
  logic meta_reg;   // first stage, read only by the second
  logic sync_reg;   // second stage
  logic prev_reg;   // delayed copy for edge detect

  // two-stage synchroniser plus history bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= asyncIn;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign rise = sync_reg & ~prev_reg;
  assign fall = ~sync_reg & prev_reg;
endmodule // dmct_sync_edge

//--- core/dmct_half_count.sv
`include "dmct_defines.svh"

module dmct_half_count (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // count control
  input  wire logic              tick,
  input  wire logic              clr,
  input  wire logic              load,
  input  wire dmct_pkg::dmct_byte_t loadData,
  // compare byte load
  input  wire logic              cmpLoad,
  input  wire dmct_pkg::dmct_byte_t cmpData,
  // state
  output dmct_pkg::dmct_byte_t   countVal,
  output dmct_pkg::dmct_byte_t   cmpVal,
  output logic                   atMax,
  output logic                   eq
);
  dmct_pkg::dmct_byte_t count_reg, count_next;   // counter byte
  dmct_pkg::dmct_byte_t cmp_reg, cmp_next;       // compare byte

  // a cpu write beats a clear, a clear beats an increment
  assign count_next = load ? loadData :
                      clr  ? `DMCT_BYTE_ZERO :
                      tick ? count_reg + 8'h01 : count_reg;
  assign cmp_next   = cmpLoad ? cmpData : cmp_reg;

  // counter and compare storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_reg <= `DMCT_RST_COUNT;   // RULE11
      cmp_reg   <= `DMCT_RST_COMPARE; // RULE11
    end else begin
      count_reg <= count_next;
      cmp_reg   <= cmp_next;
    end
  end

  assign countVal = count_reg;
  assign cmpVal   = cmp_reg;
  assign atMax    = (count_reg == `DMCT_BYTE_MAX);
  assign eq       = (count_reg == cmp_reg);
endmodule // dmct_half_count

//--- core/dmct_timer.sv
`include "dmct_defines.svh"

// Summary of operation
// (RULE1) low overflow irq needs low enable bit
// (RULE2) low clear-on-match zeroes low counter
// (RULE3) standby bit zero stops whole timer
// (RULE4) cpu accesses 16-bit pairs high first
// (RULE5) 8-bit mode bytes go direct
// (RULE6) high write latches, low write commits both
// (RULE7) high count read latches low byte
// (RULE8) compare reads bypass the byte latch
// (RULE9) select MSB zero gives one 16-bit counter
// (RULE10) select MSB one splits two counters
// (RULE11) reset: count zero, compare ones, control zero
// (RULE12) 16-bit match sets flag, irq, clear
// (RULE13) 16-bit overflow sets flag, gated irq
// (RULE14) each 8-bit half: match flag, irq, clear
// (RULE15) each 8-bit half: overflow flag, gated irq
// (RULE16) toggle output starts at level, flips on match
// (RULE17) internal clocks: div 32, 16, 4, sub/4
// (RULE18) select MSB zero counts external edges
// (RULE19) external pulses last two clocks minimum
// (RULE20) match acts as counter leaves matching value
// (RULE21) sub clock synchronised to system clock
// (RULE22) sub modes count only on sub/4
// (RULE23) flags: hardware sets, read-one-write-zero clears
// (RULE24) level bit write drives toggle output now
// (RULE25) standby halts count and holds registers
module dmct_timer (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // cpu byte port
  input  wire logic [2:0]           cpuAddr,
  input  wire logic                 cpuWrite,
  input  wire logic                 cpuRead,
  input  wire dmct_pkg::dmct_byte_t cpuWdata,
  output dmct_pkg::dmct_byte_t      cpuRdata,
  // interrupt controller side
  input  wire logic                 highIrqEnable,
  input  wire logic                 lowIrqEnable,
  input  wire logic                 eventEdgeSelect,
  output logic                      highIrqReq,
  output logic                      lowIrqReq,
  // power modes
  input  wire logic                 subMode,
  input  wire logic                 standbyMode,
  // pins
  input  wire logic                 eventInputPin,
  input  wire logic                 subClockPin,
  output logic                      highToggleOutput,
  output logic                      lowToggleOutput
);
  ////////////////////////////////////////////////////////////////////////////
  // declarations
  dmct_pkg::dmct_byte_t ctrl_reg, ctrl_next;       // control register
  dmct_pkg::dmct_byte_t stat_reg, stat_next;       // control/status register
  dmct_pkg::dmct_byte_t clkStop_reg, clkStop_next; // clock stop register
  dmct_pkg::dmct_byte_t armed_reg, armed_next;     // flags seen as one
  dmct_pkg::dmct_byte_t latch_reg, latch_next;     // byte latch
  dmct_pkg::dmct_byte_t rdata_reg, rdata_next;     // read data
  logic [4:0]           pre_reg;                   // system prescaler
  logic [1:0]           subDiv_reg;                // sub clock divider
  logic                 hOut_reg, hOut_next;       // high toggle pin
  logic                 lOut_reg, lOut_next;       // low toggle pin
  logic                 hIrq_reg, lIrq_reg;        // irq request pulses

  // half counter state
  dmct_pkg::dmct_byte_t hiCount, loCount, hiCmp, loCmp;
  logic                 hiMax, loMax, hiEq, loEq;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  wire running  = clkStop_reg[`DMCT_CLKSTOP_TIMER] & ~standbyMode;   // RULE3 RULE25
  wire wrOk     = cpuWrite & running;                                // RULE25
  wire selCtrl  = (cpuAddr == `DMCT_ADDR_CTRL);
  wire selStat  = (cpuAddr == `DMCT_ADDR_STAT);
  wire selCntHi = (cpuAddr == `DMCT_ADDR_CNT_HI);
  wire selCntLo = (cpuAddr == `DMCT_ADDR_CNT_LO);
  wire selCmpHi = (cpuAddr == `DMCT_ADDR_CMP_HI);
  wire selCmpLo = (cpuAddr == `DMCT_ADDR_CMP_LO);
  wire selStop  = (cpuAddr == `DMCT_ADDR_CLKSTOP);
  wire ctrlWr   = wrOk & selCtrl;
  wire statWr   = wrOk & selStat;
  wire statRd   = cpuRead & selStat;

  ////////////////////////////////////////////////////////////////////////////
  // mode and field decode
  wire mode16 = ~ctrl_reg[`DMCT_CTRL_HSEL_MSB];   // RULE9 RULE10
  wire [2:0] loSel = ctrl_reg[`DMCT_CTRL_LSEL_MSB:`DMCT_CTRL_LSEL_LSB];
  wire [2:0] hiSel = ctrl_reg[`DMCT_CTRL_HSEL_MSB:`DMCT_CTRL_HSEL_LSB];
  wire high_overflow_irq_enable = stat_reg[`DMCT_STAT_OVIE_H];
  wire high_clear_on_match = stat_reg[`DMCT_STAT_CCLR_H];
  wire low_overflow_irq_enable = stat_reg[`DMCT_STAT_OVIE_L];
  wire low_clear_on_match = stat_reg[`DMCT_STAT_CCLR_L];

  ////////////////////////////////////////////////////////////////////////////
  // counting clocks
  // the sub clock comes from another oscillator, so it is synchronised and
  // its edges are counted here; this costs up to one system period of jitter
  logic subRise;
  logic evRise, evFall;

  dmct_sync_edge uSubSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (subClockPin),
    .rise    (subRise),
    .fall    ()
  ); // RULE21

  // external events need two system clocks per level to survive this stage
  dmct_sync_edge uEvSync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (eventInputPin),
    .rise    (evRise),
    .fall    (evFall)
  ); // RULE19

  // the prescaler is never restarted, so the first period after a select
  // change may be short; software needing an exact first interval must
  // write the counter after choosing the clock
  // prescaler and sub divider free-run; only the taps are gated
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_reg    <= 5'h00;
      subDiv_reg <= 2'h0;
    end else begin
      pre_reg    <= pre_reg + 5'h01;
      subDiv_reg <= subRise ? subDiv_reg + 2'h1 : subDiv_reg;
    end
  end

  wire div32   = (pre_reg == `DMCT_PRE_DIV32);        // RULE17
  wire div16   = (pre_reg[3:0] == `DMCT_PRE_DIV16);   // RULE17
  wire div4    = (pre_reg[1:0] == `DMCT_PRE_DIV4);    // RULE17
  wire subTick = subRise & (subDiv_reg == `DMCT_SUB_DIV4);
  wire evTick  = eventEdgeSelect ? evRise : evFall;   // RULE18
  wire [3:0] intTicks = {subTick, div4, div16, div32};

  // in sub modes only the sub clock tap may count
  wire loAllowed = ~subMode | (loSel == `DMCT_SEL_SUB_FULL);  // RULE22
  wire hiAllowed = ~subMode | (hiSel[1:0] == `DMCT_SEL_SUB);  // RULE22
  wire loSrc  = loSel[2] ? intTicks[loSel[1:0]] : evTick;     // RULE18
  wire loTick = running & loAllowed & loSrc;
  wire hi8Tick = running & hiAllowed & intTicks[hiSel[1:0]];  // RULE10

  ////////////////////////////////////////////////////////////////////////////
  // byte-port writes into counter and compare
  wire cntHiWr = wrOk & selCntHi;
  wire cntLoWr = wrOk & selCntLo;
  wire cmpHiWr = wrOk & selCmpHi;
  wire cmpLoWr = wrOk & selCmpLo;
  // 16-bit mode: high byte waits in the latch for the low byte
  wire hiCntLoad = mode16 ? cntLoWr : cntHiWr;                // RULE5 RULE6
  wire hiCmpLoad = mode16 ? cmpLoWr : cmpHiWr;                // RULE5 RULE6
  wire dmct_pkg::dmct_byte_t hiWrData = mode16 ? latch_reg : cpuWdata; // RULE6

  ////////////////////////////////////////////////////////////////////////////
  // match, overflow and clear events
  // in 16-bit mode both halves clear on the same edge, so a read never
  // sees a half-cleared word
  // a match fires as the counter leaves the matching value; a write to the
  // counter or compare byte in the same cycle cancels it
  wire fullMatch = loTick & loEq & hiEq & ~cmpLoWr & ~cntLoWr;  // RULE20
  wire loMatch   = loTick & loEq & ~cmpLoWr & ~cntLoWr;         // RULE20
  wire loOvf     = loTick & loMax & ~cntLoWr;
  wire hiTick    = mode16 ? loTick & loMax : hi8Tick;           // RULE9
  wire hiMatch8  = hiTick & hiEq & ~hiCmpLoad & ~hiCntLoad;     // RULE20
  wire hiOvf     = hiTick & hiMax & ~hiCntLoad;                 // RULE13 RULE15
  wire hiMatch   = mode16 ? fullMatch : hiMatch8;               // RULE12 RULE14
  wire loClr     = mode16 ? fullMatch & high_clear_on_match : loMatch & low_clear_on_match;  // RULE2 RULE12
  wire hiClr     = mode16 ? fullMatch & high_clear_on_match : hiMatch8 & high_clear_on_match; // RULE12 RULE14

  dmct_half_count uHigh (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .tick     (hiTick),
    .clr      (hiClr),
    .load     (hiCntLoad),
    .loadData (hiWrData),
    .cmpLoad  (hiCmpLoad),
    .cmpData  (hiWrData),
    .countVal (hiCount),
    .cmpVal   (hiCmp),
    .atMax    (hiMax),
    .eq       (hiEq)
  );

  dmct_half_count uLow (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .tick     (loTick),
    .clr      (loClr),
    .load     (cntLoWr),
    .loadData (cpuWdata),
    .cmpLoad  (cmpLoWr),
    .cmpData  (cpuWdata),
    .countVal (loCount),
    .cmpVal   (loCmp),
    .atMax    (loMax),
    .eq       (loEq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // byte latch
  // the high write parks data here; a high count read parks the low count
  wire cntHiRd = cpuRead & selCntHi & mode16;
  wire cntLoRd = cpuRead & selCntLo;
  assign latch_next = (mode16 & (cntHiWr | cmpHiWr)) ? cpuWdata :  // RULE6
                      cntHiRd ? loCount : latch_reg;                // RULE7

  ////////////////////////////////////////////////////////////////////////////
  // control and status registers
  // event bits line up with the flag positions of the status register
  wire dmct_pkg::dmct_byte_t setEv = {hiOvf, hiMatch, 2'b00,
                                      loOvf, loMatch, 2'b00};       // RULE12 RULE13 RULE14 RULE15
  // only a zero written over a flag already read as one clears it
  wire dmct_pkg::dmct_byte_t clrEv = statWr ? (armed_reg & ~cpuWdata) : 8'h00; // RULE23
  // a set in the same cycle as a clear wins
  assign stat_next = (((stat_reg & ~clrEv) | setEv) & `DMCT_STAT_FLAGS) |
                     ((statWr ? cpuWdata : stat_reg) & ~`DMCT_STAT_FLAGS); // RULE1 RULE2 RULE23
  assign armed_next = statRd ? (stat_reg & `DMCT_STAT_FLAGS) :
                      statWr ? 8'h00 : armed_reg;                   // RULE23
  assign ctrl_next    = ctrlWr ? cpuWdata : ctrl_reg;
  // the clock stop register must stay writable to leave standby
  assign clkStop_next = (cpuWrite & selStop) ? cpuWdata : clkStop_reg; // RULE3

  // any status write drops the armed copy, so a stale read can never
  // clear a flag that hardware set after that read
  // register storage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_reg    <= `DMCT_RST_CTRL;      // RULE11
      stat_reg    <= `DMCT_RST_STAT;      // RULE11
      clkStop_reg <= `DMCT_RST_CLKSTOP;   // RULE3
      armed_reg   <= `DMCT_BYTE_ZERO;
      latch_reg   <= `DMCT_BYTE_ZERO;
    end else begin
      ctrl_reg    <= ctrl_next;
      stat_reg    <= stat_next;
      clkStop_reg <= clkStop_next;
      armed_reg   <= armed_next;
      latch_reg   <= latch_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // toggle outputs
  // a level write beats a match in the same cycle; the low pin only toggles
  // in 8-bit mode because its match is partial in 16-bit mode
  assign hOut_next = ctrlWr ? cpuWdata[`DMCT_CTRL_HOL] :            // RULE24
                     hiMatch ? ~hOut_reg : hOut_reg;                // RULE16
  assign lOut_next = ctrlWr ? cpuWdata[`DMCT_CTRL_LOL] :            // RULE24
                     (loMatch & ~mode16) ? ~lOut_reg : lOut_reg;    // RULE16

  ////////////////////////////////////////////////////////////////////////////
  // interrupt requests
  wire hIrqNext = highIrqEnable & (hiMatch | (hiOvf & high_overflow_irq_enable));      // RULE12 RULE13
  wire lIrqNext = lowIrqEnable & ((loMatch & ~mode16) | (loOvf & low_overflow_irq_enable)); // RULE1 RULE14 RULE15

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  // compare bytes and the high count byte come straight from storage
  always_comb begin
    case (cpuAddr)
      `DMCT_ADDR_CTRL:    rdata_next = ctrl_reg;
      `DMCT_ADDR_STAT:    rdata_next = stat_reg;
      `DMCT_ADDR_CNT_HI:  rdata_next = hiCount;                       // RULE7
      `DMCT_ADDR_CNT_LO:  rdata_next = mode16 ? latch_reg : loCount;  // RULE5 RULE7
      `DMCT_ADDR_CMP_HI:  rdata_next = hiCmp;                         // RULE8
      `DMCT_ADDR_CMP_LO:  rdata_next = loCmp;                         // RULE8
      `DMCT_ADDR_CLKSTOP: rdata_next = clkStop_reg;
      default:            rdata_next = `DMCT_BYTE_ZERO;
    endcase
  end

  // read data is held between reads, so a slow cpu may take it late;
  // the cost is one flop stage of read latency
  // output flops: pins, irq pulses and read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hOut_reg  <= 1'b0;
      lOut_reg  <= 1'b0;
      hIrq_reg  <= 1'b0;
      lIrq_reg  <= 1'b0;
      rdata_reg <= `DMCT_BYTE_ZERO;
    end else begin
      hOut_reg  <= hOut_next;
      lOut_reg  <= lOut_next;
      hIrq_reg  <= hIrqNext;
      lIrq_reg  <= lIrqNext;
      rdata_reg <= cpuRead ? rdata_next : rdata_reg;
    end
  end

  assign cpuRdata         = rdata_reg;
  assign highToggleOutput = hOut_reg;
  assign lowToggleOutput  = lOut_reg;
  assign highIrqReq       = hIrq_reg;
  assign lowIrqReq        = lIrq_reg;
endmodule // dmct_timer

//--- dv/dmct_timer_monitor.sv
////////////////////////////////////////////////////////////////////////////////
module dmct_timer_monitor (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst,
  // byte port
  input wire logic [2:0]           cpuAddr,
  input wire logic                 cpuWrite,
  input wire logic                 cpuRead,
  input wire dmct_pkg::dmct_byte_t cpuWdata,
  input wire dmct_pkg::dmct_byte_t cpuRdata,
  // interrupt side and power
  input wire logic                 highIrqEnable,
  input wire logic                 lowIrqEnable,
  input wire logic                 highIrqReq,
  input wire logic                 lowIrqReq,
  input wire logic                 standbyMode,
  // toggle pins
  input wire logic                 highToggleOutput,
  input wire logic                 lowToggleOutput
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of the run bit; address 6 stays writable in standby
  logic runBit;
  always_ff @(posedge sys_clk) begin
    if (rst) runBit <= 1'h1;
    else if (cpuWrite && cpuAddr == 3'h6) runBit <= cpuWdata[2];
  end
  // a control write that the timer must honour
  wire ctrlWr = cpuWrite && cpuAddr == 3'h0 && !standbyMode && runBit;
  wire halted = standbyMode || !runBit;
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'h0) rst |=> cpuRdata == 8'h00
    && !highIrqReq && !lowIrqReq && !highToggleOutput && !lowToggleOutput)
    else $error("outputs not quiet after reset");
  a_rdata_hold: assert property (!cpuRead |=> $stable(cpuRdata))
    else $error("read data moved without a read");
  a_unmapped_read: assert property (cpuRead && cpuAddr == 3'h7 |=> cpuRdata == 8'h00)
    else $error("unmapped read not zero");
  a_level_write: assert property (ctrlWr |=>
    highToggleOutput == $past(cpuWdata[7]) && lowToggleOutput == $past(cpuWdata[3]))
    else $error("toggle pins ignore level bits");
  a_standby_hold: assert property (halted |=>
    $stable(highToggleOutput) && $stable(lowToggleOutput))
    else $error("toggle moved in standby");
  a_hirq_gate: assert property (highIrqReq |->
    $past(highIrqEnable) || $past(highIrqEnable, 2))
    else $error("high request without enable");
  a_lirq_gate: assert property (lowIrqReq |->
    $past(lowIrqEnable) || $past(lowIrqEnable, 2))
    else $error("low request without enable");
  a_irq_pulse: assert property (highIrqReq || lowIrqReq |=>
    !(highIrqReq && $past(highIrqReq)) && !(lowIrqReq && $past(lowIrqReq)))
    else $error("request longer than one cycle");
  // main scenarios seen
  c_level: cover property (ctrlWr);
  c_hirq: cover property (highIrqReq);
  c_lirq: cover property (lowIrqReq);
  c_cnt_read: cover property (cpuRead && cpuAddr == 3'h2);
endmodule // dmct_timer_monitor

bind dmct_timer dmct_timer_monitor i_mon (
  .sys_clk(sys_clk), .rst(rst), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
  .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
  .highIrqEnable(highIrqEnable), .lowIrqEnable(lowIrqEnable),
  .highIrqReq(highIrqReq), .lowIrqReq(lowIrqReq), .standbyMode(standbyMode),
  .highToggleOutput(highToggleOutput), .lowToggleOutput(lowToggleOutput));

//--- dv/dmct_cpu_model.sv
////////////////////////////////////////////////////////////////////////////////
module dmct_cpu_model (
  // clock
  input  wire logic                 sys_clk,
  // byte port toward the timer
  output logic [2:0]                cpuAddr,
  output logic                      cpuWrite,
  output logic                      cpuRead,
  output dmct_pkg::dmct_byte_t      cpuWdata,
  input  wire dmct_pkg::dmct_byte_t cpuRdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cpuAddr  = 3'h0;
    cpuWrite = 1'h0;
    cpuRead  = 1'h0;
    cpuWdata = 8'h00;
  end
  // one byte write; data inverted afterwards so stale bytes never look valid
  task automatic wr(input logic [2:0] a, input dmct_pkg::dmct_byte_t d);
    @(posedge sys_clk);
    #1;
    cpuAddr  = a;
    cpuWdata = d;
    cpuWrite = 1'h1;
    @(posedge sys_clk);
    #1;
    cpuWrite = 1'h0;
    cpuWdata = ~d;
  endtask
  // one byte read; the answer is registered at the taking edge
  task automatic rd(input logic [2:0] a, output dmct_pkg::dmct_byte_t d);
    @(posedge sys_clk);
    #1;
    cpuAddr = a;
    cpuRead = 1'h1;
    @(posedge sys_clk);
    #1;
    cpuRead = 1'h0;
    d       = cpuRdata;
  endtask
  // word transfers always go upper byte first
  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 3'h1, v[7:0]);
  endtask
  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 3'h1, v[7:0]);
  endtask
endmodule // dmct_cpu_model

//--- dv/tb_top.sv
////////////////////////////////////////////////////////////////////////////////
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 sys_clk, rst, highIrqEnable, lowIrqEnable, eventEdgeSelect;
  logic                 subMode, standbyMode, eventInputPin, subClockPin, cpuWrite, cpuRead;
  logic                 highIrqReq, lowIrqReq, highToggleOutput, lowToggleOutput;
  logic [2:0]           cpuAddr;
  logic [15:0]          h;
  dmct_pkg::dmct_byte_t cpuWdata, cpuRdata, v, w;
  int                   error_cnt, cmp_count, hiIrq, loIrq, cyc;
  // expected register values straight after reset, index = address
  dmct_pkg::dmct_byte_t rstVal [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  dmct_timer i_dut (
    .sys_clk(sys_clk), .rst(rst), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite),
    .cpuRead(cpuRead), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .highIrqEnable(highIrqEnable), .lowIrqEnable(lowIrqEnable),
    .eventEdgeSelect(eventEdgeSelect), .highIrqReq(highIrqReq), .lowIrqReq(lowIrqReq),
    .subMode(subMode), .standbyMode(standbyMode), .eventInputPin(eventInputPin),
    .subClockPin(subClockPin), .highToggleOutput(highToggleOutput),
    .lowToggleOutput(lowToggleOutput));
  dmct_cpu_model i_cpu (
    .sys_clk(sys_clk), .cpuAddr(cpuAddr), .cpuWrite(cpuWrite), .cpuRead(cpuRead),
    .cpuWdata(cpuWdata), .cpuRdata(cpuRdata));

  // system clock, 100 ns
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // sub clock, unrelated in phase to the system clock
  initial begin
    subClockPin = 1'h0;
    #13;
    forever #350 subClockPin = ~subClockPin;
  end
  // request counters and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (highIrqReq === 1'h1) hiIrq++;
    if (lowIrqReq === 1'h1) loIrq++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rep(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // one rising then falling event, each level held four clocks
  task automatic ev();
    eventInputPin = 1'h1;
    rep(4);
    eventInputPin = 1'h0;
    rep(4);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {highIrqEnable, lowIrqEnable, eventEdgeSelect} = 3'h7;
    {subMode, standbyMode, eventInputPin} = 3'h0;
    rst = 1'h1;
    rep(8);
    rst = 1'h0;
    for (int a = 0; a < 8; a++) begin
      i_cpu.rd(a[2:0], v);
      chk(v, rstVal[a]);
    end
    $display("test reset values done");
    // word path through the byte latch, counter on external events
    i_cpu.wr(3'h2, 8'hAB);
    i_cpu.rd(3'h4, v);
    chk(v, 8'hFF);
    i_cpu.wr(3'h3, 8'hCD);
    i_cpu.rd16(3'h2, h);
    chk(h, 16'hABCD);
    i_cpu.rd(3'h2, v);
    ev();
    i_cpu.rd(3'h5, v);
    chk(v, 8'hFF);
    i_cpu.rd(3'h3, v);
    chk(v, 8'hCD);
    i_cpu.rd16(3'h2, h);
    chk(h, 16'hABCE);
    $display("test byte latch done");
    // word match with clear, then word overflow
    i_cpu.wr16(3'h4, 16'h0002);
    i_cpu.wr16(3'h2, 16'h0000);
    i_cpu.wr(3'h1, 8'h30);
    // falling edges only from here: a lone rising edge must not count
    eventEdgeSelect = 1'h0;
    eventInputPin = 1'h1;
    rep(4);
    i_cpu.rd16(3'h2, h);
    chk(h, 16'h0000);
    eventInputPin = 1'h0;
    rep(4);
    ev();
    i_cpu.rd(3'h1, v);
    chk(v, 8'h30);
    ev();
    i_cpu.rd(3'h1, v);
    chk(v, 8'h74);
    i_cpu.rd16(3'h2, h);
    chk(h, 16'h0000);
    chk(highToggleOutput, 1'h1);
    chk(hiIrq[15:0], 16'h1);
    i_cpu.wr(3'h1, 8'h30);
    i_cpu.rd(3'h1, v);
    chk(v, 8'h30);
    i_cpu.wr(3'h1, 8'hF0);
    i_cpu.rd(3'h1, v);
    chk(v, 8'h30);
    i_cpu.wr16(3'h2, 16'hFFFF);
    ev();
    i_cpu.rd(3'h1, v);
    chk(v, 8'hB8);
    chk(hiIrq[15:0], 16'h2);
    chk(loIrq[15:0], 16'h0);
    i_cpu.wr(3'h1, 8'h00);
    i_cpu.rd(3'h1, v);
    chk(v, 8'h00);
    $display("test word mode done");
    // split halves: high on div 32, low on div 4
    i_cpu.wr16(3'h4, 16'h0005);
    i_cpu.wr16(3'h2, 16'h00FE);
    i_cpu.wr(3'h1, 8'h03);
    i_cpu.wr(3'h0, 8'h46);
    rep(40);
    i_cpu.wr(3'h5, 8'h80);
    i_cpu.rd(3'h1, v);
    chk(v, 8'h4F);
    chk(loIrq[15:0], 16'h2);
    chk(hiIrq[15:0], 16'h3);
    chk({highToggleOutput, lowToggleOutput}, 2'h3);
    i_cpu.rd(3'h3, v);
    chk(v < 8'h08, 1'h1);
    lowIrqEnable = 1'h0;
    i_cpu.wr(3'h1, 8'h02);
    i_cpu.wr(3'h3, 8'hFE);
    rep(12);
    i_cpu.rd(3'h1, v);
    chk(v, 8'h0A);
    chk(loIrq[15:0], 16'h2);
    lowIrqEnable = 1'h1;
    $display("test byte mode done");
    // halt causes: run bit, standby pin, sub mode with a fast clock
    for (int m = 0; m < 3; m++) begin
      if (m == 0) i_cpu.wr(3'h6, 8'hFB);
      else if (m == 1) standbyMode = 1'h1;
      else subMode = 1'h1;
      rep(2);
      i_cpu.rd(3'h3, v);
      rep(20);
      i_cpu.rd(3'h3, w);
      chk(w, v);
      if (m == 0) begin
        i_cpu.wr(3'h0, 8'h88);
        i_cpu.rd(3'h0, v);
        chk(v, 8'h46);
      end
      i_cpu.wr(3'h6, 8'hFF);
      standbyMode = 1'h0;
      subMode = 1'h0;
    end
    $display("test halt done");
    // level bits drive the pins, then sub clock keeps counting in sub mode
    i_cpu.wr(3'h0, 8'h47);
    chk({highToggleOutput, lowToggleOutput}, 2'h0);
    subMode = 1'h1;
    i_cpu.rd(3'h3, v);
    rep(80);
    i_cpu.rd(3'h3, w);
    chk(w !== v, 1'h1);
    subMode = 1'h0;
    $display("test sub clock done");
    stop_test();
  end
endmodule // tb_top
